// [rtl/flag_conditional_short_branch.sv]
// decode and execution of the flag conditional short branches
`timescale 1ns/1ps
`include "branch_consts.svh"
module flag_conditional_short_branch #(
   parameter int PC_WIDTH = 21
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // fetched instruction and its valid strobe, sampled in Q1, the literal byte read again in Q2
   input wire branch_pkg::fetch_type fetch,
   input wire logic fetch_valid,
   // status flags from the core
   input wire logic [7:0] status,
   // program counter write
   output branch_pkg::pc_write_type pc_write,
   // prefetch flush and stall for the idle cycle
   output logic flush,
   output logic busy,
   // status flags passed on unchanged
   output logic [7:0] status_out,
   // one of the four branches recognised this cycle
   output logic is_branch,
   // current phase, registered
   output logic [1:0] phase_out
);
   // phase number of the current clock and the end of cycle pulse
   logic [1:0] phase;
   logic cycle_end;

   // four phase generator, phase number per clock and one end pulse per cycle
   phase_divider i_phase_divider (
      .clock(clock),
      .reset(reset),
      .phase(phase),
      .cycle_end(cycle_end)
   );

   // decode a word into its branch condition
   function automatic branch_pkg::cond_type decode(input logic [15:0] word);
      branch_pkg::cond_type c;
      c = branch_pkg::cond_none_type_v;
      // only the branch family prefix can hold one of the four
      if (word[`BR_FAMILY_MSB:`BR_FAMILY_LSB] == `BR_FAMILY) begin
         case (word[`BR_SEL_MSB:`BR_SEL_LSB])
            `BR_SEL_NEG: c = branch_pkg::branch_on_negative;
            `BR_SEL_NO_CARRY: c = branch_pkg::branch_on_carry_clear;
            `BR_SEL_NOT_NEG: c = branch_pkg::branch_on_not_negative;
            `BR_SEL_NO_OVF: c = branch_pkg::branch_on_no_overflow;
            // other selectors belong to instructions outside this block
            default: c = branch_pkg::cond_none_type_v;
         endcase
      end
      return c;
   endfunction

   // test a decoded condition against the status flags
   function automatic logic cond_holds(input branch_pkg::cond_type c,
      input logic [7:0] flags);
      logic h;
      h = 1'b0;
      case (c)
         branch_pkg::branch_on_negative: h = flags[`FLAG_NEG];
         branch_pkg::branch_on_carry_clear: h = ~flags[`FLAG_CARRY];
         branch_pkg::branch_on_not_negative: h = ~flags[`FLAG_NEG];
         branch_pkg::branch_on_no_overflow: h = ~flags[`FLAG_OVF];
         // no branch decoded: never taken
         default: h = 1'b0;
      endcase
      return h;
   endfunction

   // states of one branch: none, first cycle, idle second cycle
   typedef enum logic [1:0] {idle_type_s, exec_type_s, dead_type_s} state_type;
   state_type state_reg; // where the current instruction stands
   branch_pkg::cond_type fetch_cond; // condition of the word on the fetch port
   logic fetch_hit; // valid fetch of one of the four branches
   branch_pkg::cond_type cond_reg; // decoded in Q1
   logic [`BR_LIT_WIDTH-1:0] literal_reg; // read in Q2
   logic [PC_WIDTH-1:0] address_reg; // own address, captured in Q1
   logic [PC_WIDTH-1:0] target_reg; // computed in Q3
   logic taken_reg; // condition outcome, settled in Q3
   logic [PC_WIDTH-1:0] offset_ext; // doubled and sign extended literal
   logic live_q1; // Q1 of a cycle that may start an instruction
   logic write_now; // Q4 of a taken branch

   // decode the fetch word once for every user
   assign fetch_cond = decode(fetch.word);
   assign fetch_hit = fetch_valid && fetch_cond != branch_pkg::cond_none_type_v;

   // the cycle after a taken branch decodes nothing
   assign live_q1 = (phase == `PH_Q1) && !(state_reg == exec_type_s && taken_reg);

   // counter write and flush happen at the end of Q4 of a taken branch
   assign write_now = (phase == `PH_Q4) && state_reg == exec_type_s && taken_reg;

   // sign extend to the counter width and double the literal
   assign offset_ext = {{(PC_WIDTH-`BR_LIT_WIDTH-1){literal_reg[`BR_LIT_WIDTH-1]}},
      literal_reg, 1'b0};

   // instruction state, advanced in Q1 only
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= idle_type_s;
      end else if (phase == `PH_Q1) begin
         if (state_reg == exec_type_s && taken_reg) begin
            // a taken branch spends the next cycle idle
            state_reg <= dead_type_s;
         end else if (fetch_hit) begin
            // one of the four branches starts its first cycle
            state_reg <= exec_type_s;
         end else begin
            // any other word, or no valid fetch, is not ours
            state_reg <= idle_type_s;
         end
      end
   end

   // condition and own address, captured in Q1 of a live cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         cond_reg <= branch_pkg::cond_none_type_v;
         address_reg <= '0;
      end else if (live_q1 && fetch_hit) begin
         // decode step of the first cycle
         cond_reg <= fetch_cond;
         address_reg <= fetch.address[PC_WIDTH-1:0];
      end
   end

   // offset literal, read in Q2 of the first cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         literal_reg <= '0;
      end else if (phase == `PH_Q2 && state_reg == exec_type_s) begin
         // low byte of the instruction word
         literal_reg <= fetch.word[`BR_LIT_WIDTH-1:0];
      end
   end

   // branch target, processed in Q3 of the first cycle
   always_ff @(posedge clock) begin
      if (reset) begin
         target_reg <= '0;
      end else if (phase == `PH_Q3 && state_reg == exec_type_s) begin
         // the counter has already stepped past this word
         target_reg <= address_reg + PC_WIDTH'(`PC_STEP) + offset_ext;
      end
   end

   // condition outcome, processed in Q3; cleared in Q3 of other cycles
   always_ff @(posedge clock) begin
      if (reset) begin
         taken_reg <= 1'b0;
      end else if (phase == `PH_Q3) begin
         if (state_reg == exec_type_s) begin
            // flags are only read, never written
            taken_reg <= cond_holds(cond_reg, status);
         end else begin
            // no live branch in this cycle
            taken_reg <= 1'b0;
         end
      end
   end

   // counter write in Q4 only when taken
   always_ff @(posedge clock) begin
      if (reset) begin
         pc_write <= '0;
      end else begin
         // one clock pulse, seen during the following Q1
         pc_write.write <= write_now;
         // value only matters while the write bit is high
         pc_write.value <= 21'(target_reg);
      end
   end

   // discard the prefetched word together with the counter write
   always_ff @(posedge clock) begin
      if (reset) begin
         flush <= 1'b0;
      end else begin
         flush <= write_now;
      end
   end

   // busy during the idle second cycle of a taken branch
   always_ff @(posedge clock) begin
      if (reset) begin
         busy <= 1'b0;
      end else if (cycle_end) begin
         // set for the dead cycle, dropped at its end
         busy <= state_reg == exec_type_s && taken_reg;
      end
   end

   // flags pass through untouched
   always_ff @(posedge clock) begin
      if (reset) begin
         status_out <= '0;
      end else begin
         status_out <= status;
      end
   end

   // report a valid fetch of one of the four branches
   always_ff @(posedge clock) begin
      if (reset) begin
         is_branch <= 1'b0;
      end else begin
         is_branch <= fetch_hit;
      end
   end

   // registered copy of the phase for the core's sequencer
   always_ff @(posedge clock) begin
      if (reset) begin
         phase_out <= `PH_Q1;
      end else begin
         phase_out <= phase;
      end
   end
endmodule

// [rtl/branch_consts.svh]
// constants for the flag conditional short branch block
`ifndef BRANCH_CONSTS_SVH
`define BRANCH_CONSTS_SVH
// high nibble family prefix of the short conditional branches
`define BR_FAMILY 4'he
// field positions within the instruction word
`define BR_FAMILY_MSB 15
`define BR_FAMILY_LSB 12
`define BR_SEL_MSB 11
`define BR_SEL_LSB 8
// width of the signed offset literal in the low byte
`define BR_LIT_WIDTH 8
// low nibble of the upper byte selecting the condition
`define BR_SEL_NEG 4'h6
`define BR_SEL_NO_CARRY 4'h3
`define BR_SEL_NOT_NEG 4'h7
`define BR_SEL_NO_OVF 4'h5
// phase numbers within an instruction cycle
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3
// status flag bit positions
`define FLAG_CARRY 0
`define FLAG_OVF 3
`define FLAG_NEG 4
// word step of the program counter
`define PC_STEP 2
`endif

// [rtl/branch_pkg.sv]
// types for the flag conditional short branch block
package branch_pkg;
   // condition decoded from the upper byte
   typedef enum logic [2:0] {
      cond_none_type_v,
      branch_on_negative,
      branch_on_carry_clear,
      branch_on_not_negative,
      branch_on_no_overflow
   } cond_type;
   // one fetched instruction with its own address
   typedef struct packed {
      logic [20:0] address;
      logic [15:0] word;
   } fetch_type;
   // program counter write request
   typedef struct packed {
      logic write;
      logic [20:0] value;
   } pc_write_type;
endpackage

// [rtl/phase_divider.sv]
// four phase divider: a phase number per clock and one end pulse per instruction cycle
`timescale 1ns/1ps
`include "branch_consts.svh"
module phase_divider (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // phase number and end of cycle pulse
   output logic [1:0] phase,
   output logic cycle_end
);
   // phase counter advances every clock
   always_ff @(posedge clock) begin
      if (reset) begin
         phase <= `PH_Q1;
      end else begin
         phase <= phase + 2'h1;
      end
   end
   // pulse during the last phase of each cycle
   assign cycle_end = (phase == `PH_Q4);
endmodule

// [dv/branch_checker.sv]
// concurrent checks on the ports of the short branch block
`timescale 1ns/1ps
module branch_checker #(
   parameter int PC_WIDTH = 21
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // watched ports
   input wire branch_pkg::fetch_type fetch,
   input wire logic fetch_valid,
   input wire logic [7:0] status,
   input wire branch_pkg::pc_write_type pc_write,
   input wire logic flush,
   input wire logic busy,
   input wire logic [7:0] status_out,
   input wire logic is_branch,
   input wire logic [1:0] phase_out
);
   default clocking dc @(posedge clock); endclocking
   default disable iff (reset);
   logic [3:0] sel; // condition nibble
   logic hit; // branch word whose condition holds
   logic [20:0] off; // doubled sign extended offset
   assign sel = fetch.word[11:8];
   assign hit = fetch.word[15:12] == 4'he && (sel == 4'h6 && status[4]
      || sel == 4'h3 && !status[0] || sel == 4'h7 && !status[4] || sel == 4'h5 && !status[3]);
   assign off = {{12{fetch.word[7]}}, fetch.word[7:0], 1'b0};
   // a valid fetch at the start of a live cycle
   sequence q1_s;
      phase_out == 2'h3 && !busy && fetch_valid;
   endsequence
   flush_match_a: assert property (flush == pc_write.write)
      else $error("flush apart from write");
   write_pulse_a: assert property (pc_write.write |=> !pc_write.write)
      else $error("write too long");
   write_phase_a: assert property (pc_write.write |-> phase_out == 2'h3)
      else $error("write off phase");
   busy_len_a: assert property (pc_write.write |-> busy[*4] ##1 !busy)
      else $error("idle cycle length");
   status_copy_a: assert property (!$past(reset) |-> status_out == $past(status))
      else $error("status altered");
   target_a: assert property (pc_write.write |->
      pc_write.value == $past(fetch.address + 21'h2 + off, 4))
      else $error("bad target");
   taken_a: assert property (q1_s ##2 hit |-> ##2 pc_write.write)
      else $error("branch not taken");
   skip_a: assert property (q1_s ##2 !hit |-> ##2 !pc_write.write)
      else $error("branch wrongly taken");
endmodule

// [dv/flag_conditional_short_branch_tb.sv]
// testbench for the flag conditional short branch block
`timescale 1ns/1ps
module flag_conditional_short_branch_tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   branch_pkg::fetch_type fetch = '0;
   logic fetch_valid = 1'b0;
   logic [7:0] status = 8'h00;
   branch_pkg::pc_write_type pc_write;
   logic flush, busy, is_branch;
   logic [7:0] status_out;
   logic [1:0] phase_out;
   int n_errors = 0;
   int checks_done = 0;
   always #5 clock = ~clock;
   flag_conditional_short_branch #(.PC_WIDTH(21)) i_flag_conditional_short_branch (
      .clock(clock), .reset(reset), .fetch(fetch), .fetch_valid(fetch_valid),
      .status(status), .pc_write(pc_write), .flush(flush), .busy(busy),
      .status_out(status_out), .is_branch(is_branch), .phase_out(phase_out));
   // compare one result
   task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // present one instruction for a whole cycle, judge its end
   task automatic run(input logic [15:0] w, input logic [20:0] a, input logic [7:0] st,
      input logic v, input logic tk);
      int i;
      logic br;
      i = 0;
      // expected decode: valid word of the family with one of the four selectors
      br = v && (w[15:12] == 4'he) && (w[11:8] inside {4'h6, 4'h3, 4'h7, 4'h5});
      while (phase_out !== 2'h3 && i < 8) begin
         @(posedge clock);
         #1;
         i++;
      end
      check("phase", 21'h3, 21'(phase_out));
      fetch = '{a, w};
      fetch_valid = v;
      status = st;
      repeat (4) @(posedge clock);
      #1;
      check("write", 21'(tk), 21'(pc_write.write));
      check("flush", 21'(tk), 21'(flush));
      check("busy", 21'(tk), 21'(busy));
      check("status", 21'(st), 21'(status_out));
      check("is_branch", 21'(br), 21'(is_branch));
      if (tk) check("target", a + 21'h2 + {{12{w[7]}}, w[7:0], 1'b0}, pc_write.value);
   endtask
   // every condition, met and failed; a branch in the dead cycle is ignored
   task automatic t_codes();
      logic [15:0] sel = 16'h5736;
      logic [3:0] lvl = 4'h1;
      int pos [4] = '{4, 0, 4, 3};
      logic [7:0] st;
      for (int k = 0; k < 8; k++) begin
         st = {8{~(lvl[k/2] ^ k[0])}};
         st[pos[k/2]] = lvl[k/2] ^ k[0];
         run({4'he, sel[k/2*4 +: 4], 8'h05}, 21'h100, st, 1'b1, !k[0]);
         if (!k[0]) run(16'he605, 21'h0, 8'h10, 1'b1, 1'b0);
      end
   endtask
   // offset extremes and counter wrap
   task automatic t_offsets();
      run(16'he780, 21'h000010, 8'h00, 1'b1, 1'b1);
      run(16'h0000, 21'h0, 8'h00, 1'b0, 1'b0);
      run(16'he67f, 21'h1ffffe, 8'h10, 1'b1, 1'b1);
      run(16'h0000, 21'h0, 8'h00, 1'b0, 1'b0);
   endtask
   // foreign words and an invalid fetch are not branches
   task automatic t_foreign();
      run(16'he105, 21'h40, 8'h00, 1'b1, 1'b0);
      run(16'h2e05, 21'h40, 8'hff, 1'b1, 1'b0);
      run(16'he605, 21'h40, 8'h10, 1'b0, 1'b0);
   endtask
   // verdict and end of run
   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clock);
      #1;
      reset = 1'b0;
      t_codes();
      t_offsets();
      t_foreign();
      finish_test();
   end
   // watchdog: tests need about 1 us
   initial begin
      #20000;
      n_errors++;
      finish_test();
   end
endmodule
bind flag_conditional_short_branch branch_checker #(.PC_WIDTH(PC_WIDTH)) i_branch_checker (
   .clock(clock), .reset(reset), .fetch(fetch), .fetch_valid(fetch_valid), .status(status),
   .pc_write(pc_write), .flush(flush), .busy(busy), .status_out(status_out),
   .is_branch(is_branch), .phase_out(phase_out));
